/* File: swp_pkg.sv */
// Overview of operation
// - master releases within 15 us for one
// - master holds low 60 us for zero
// - one bit per time slot, timing-coded
// - device is slave, fed only by line
// - first unlock code within 8 ms window
// - second unlock only after first, in window
// - exit command clears both unlocks
// - commit command copies scratchpad to array
// - codes 29h, 09h, 01h, 04h, 06h, write uncoded
// - commit sets busy, line ignored meanwhile
// - write: upper nibble address, lower data
// - read shifts 60 bits, no busy
// - reset 480 us, presence after 15-60 us
package swp_pkg;
   localparam int CLK_NS = 25;
   // master side figures
   localparam int W1_LOW_NS = 6000;
   localparam int W0_LOW_NS = 60500;
   localparam int RD_LOW_NS = 2000;
   localparam int RD_SMP_NS = 12000;
   // short slot keeps a byte near 20000 cycles while meeting the 60 us floor
   localparam int SLOT_NS = 61000;
   localparam int REC_NS = 1000;
   localparam int RST_LOW_NS = 500000;
   localparam int RST_REC_NS = 480000;
   localparam int W1_LOW_CYC = W1_LOW_NS / CLK_NS;
   localparam int W0_LOW_CYC = (W0_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_LOW_CYC = (RD_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_SMP_CYC = RD_SMP_NS / CLK_NS;
   localparam int SLOT_CYC = (SLOT_NS + REC_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_LOW_CYC = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_REC_CYC = (RST_REC_NS + CLK_NS - 1) / CLK_NS;
   // device side figures
   localparam int SAMPLE_NS = 30000;
   localparam int RST_DET_NS = 480000;
   localparam int PRES_DLY_NS = 30000;
   localparam int PRES_LEN_NS = 90000;
   localparam int RD_HOLD_NS = 15000;
   localparam int WINDOW_NS = 8000000;
   localparam int COMMIT_NS = 10000000;
   localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_DET_CYC = (RST_DET_NS + CLK_NS - 1) / CLK_NS;
   localparam int PRES_DLY_CYC = (PRES_DLY_NS + CLK_NS - 1) / CLK_NS;
   localparam int PRES_LEN_CYC = (PRES_LEN_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_HOLD_CYC = RD_HOLD_NS / CLK_NS;
   localparam int WINDOW_CYC = WINDOW_NS / CLK_NS;
   localparam int COMMIT_CYC = (COMMIT_NS + CLK_NS - 1) / CLK_NS;
   // command codes and scratchpad shape
   localparam logic [7:0] CMD_UNLOCK1 = 8'h29;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h09;
   localparam logic [7:0] EXIT_PROGRAMMING_CMD = 8'h01;
   localparam logic [7:0] COMMIT_ALL_CMD = 8'h04;
   localparam logic [7:0] SCRATCH_READ_CMD = 8'h06;
   localparam int NIB = 4;
   localparam int SCR_WORDS = 16;
   localparam int RD_FIRST = 1;
   localparam logic [5:0] RD_LAST = 6'h3B;
   localparam logic [63:0] SCR_RESET = 64'h0;
   // master operations
   localparam logic [1:0] OP_RESET = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
endpackage

/* File: swp_if.sv */
`timescale 1ns/1ps
`default_nettype none
// shared open-drain line; each end pulls low when its enable is low
interface swp_if;
   logic dev_out;
   logic dev_oe_n;
   logic mst_out;
   logic mst_oe_n;
   logic line;
   // wired-and with pull-up
   assign line = !((!dev_oe_n && !dev_out) || (!mst_oe_n && !mst_out));
   modport device (input line, output dev_out, output dev_oe_n);
   modport master (input line, output mst_out, output mst_oe_n);
endinterface
`default_nettype wire

/* File: swp_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module swp_dev import swp_pkg::*; #(
   parameter int RESET_CYC = RST_DET_CYC,
   parameter int WIN_CYC = WINDOW_CYC,
   parameter int BUSY_CYC = COMMIT_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   swp_if.device bus,
   output logic prog_mode,
   output logic busy,
   output logic commit_pulse,
   output logic [63:0] nv_image
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SLOT = 3'b001,
      ST_RSTL = 3'b011,
      ST_PWAIT = 3'b010,
      ST_PRES = 3'b110
   } swp_dst_e;

   localparam logic [14:0] SMP_L = 15'(SAMPLE_CYC - 1);
   localparam logic [14:0] RST_L = 15'(RESET_CYC);
   localparam logic [14:0] PDLY_L = 15'(PRES_DLY_CYC - 1);
   localparam logic [14:0] PLEN_L = 15'(PRES_LEN_CYC - 1);
   localparam logic [14:0] HOLD_L = 15'(RD_HOLD_CYC - 1);
   localparam logic [19:0] WIN_L = 20'(WIN_CYC);
   localparam logic [19:0] BUSY_L = 20'(BUSY_CYC - 1);

   swp_dst_e state_ff;
   logic [2:0] sync_ff;
   logic lvl_ff;
   logic prev_ff;
   logic [14:0] cnt_ff;
   logic drv_ff;
   logic [2:0] bit_ff;
   logic [7:0] sh_ff;
   logic unl1_ff;
   logic unl2_ff;
   logic rd_mode_ff;
   logic [5:0] rd_idx_ff;
   logic [3:0] scr_ff [SCR_WORDS];
   logic [63:0] scr_flat;
   logic [63:0] nv_ff;
   logic [19:0] win_ff;
   logic busy_ff;
   logic [19:0] bcnt_ff;
   logic commit_ff;
   logic fall;
   logic smp;
   logic byte_done;
   logic win_open;
   logic rd_bit;
   logic [7:0] nxt_byte;

   // line only, no other inputs during programming
   assign bus.dev_out = 1'b0;
   assign bus.dev_oe_n = ~drv_ff;
   assign prog_mode = unl2_ff;
   assign busy = busy_ff;
   assign commit_pulse = commit_ff;
   assign nv_image = nv_ff;

   // flatten scratchpad words for shifting and commit
   generate
      for (genvar i = 0; i < SCR_WORDS; i++) begin : g_flat
         assign scr_flat[NIB*i +: NIB] = scr_ff[i];
      end
   endgenerate

   // event decode
   assign fall = prev_ff & ~lvl_ff;
   assign smp = (state_ff == ST_SLOT) && (cnt_ff == SMP_L);
   assign byte_done = smp && !rd_mode_ff && (bit_ff == 3'h7);
   assign nxt_byte = {lvl_ff, sh_ff[7:1]};
   assign win_open = (win_ff < WIN_L);
   assign rd_bit = scr_flat[6'(NIB * RD_FIRST) + rd_idx_ff];

   // three-stage line synchroniser, change taken when last two agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_ff <= 3'h7;
         lvl_ff <= 1'b1;
         prev_ff <= 1'b1;
      end else begin
         sync_ff <= {sync_ff[1:0], bus.line};
         if (sync_ff[2] == sync_ff[1]) begin
            lvl_ff <= sync_ff[2];
         end
         prev_ff <= lvl_ff;
      end
   end

   // programming window timer from startup
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         win_ff <= 20'h0;
      end else if (win_open) begin
         win_ff <= win_ff + 20'h1;
      end
   end

   // slot timing, reset detection, presence and read drive
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         cnt_ff <= 15'h0;
         drv_ff <= 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               cnt_ff <= 15'h0;
               if (fall && !busy_ff) begin
                  state_ff <= ST_SLOT;
                  drv_ff <= rd_mode_ff && !rd_bit;
               end
            end
            ST_SLOT: begin
               cnt_ff <= cnt_ff + 15'h1;
               if (cnt_ff == HOLD_L) begin
                  drv_ff <= 1'b0; // release after valid time
               end
               if (lvl_ff && cnt_ff > SMP_L) begin
                  state_ff <= ST_IDLE;
               end else if (!lvl_ff && cnt_ff >= RST_L) begin
                  state_ff <= ST_RSTL;
               end
            end
            ST_RSTL: begin
               cnt_ff <= 15'h0;
               if (lvl_ff) begin
                  state_ff <= ST_PWAIT;
               end
            end
            ST_PWAIT: begin
               cnt_ff <= cnt_ff + 15'h1;
               if (cnt_ff == PDLY_L) begin
                  state_ff <= ST_PRES;
                  cnt_ff <= 15'h0;
                  drv_ff <= 1'b1;
               end
            end
            ST_PRES: begin
               cnt_ff <= cnt_ff + 15'h1;
               if (cnt_ff == PLEN_L) begin
                  state_ff <= ST_IDLE;
                  drv_ff <= 1'b0;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
               drv_ff <= 1'b0;
            end
         endcase
      end
   end

   // command byte assembly, lsb first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_ff <= 3'h0;
         sh_ff <= 8'h0;
      end else if (state_ff == ST_RSTL) begin
         bit_ff <= 3'h0;
      end else if (smp && !rd_mode_ff) begin
         sh_ff <= nxt_byte;
         bit_ff <= bit_ff + 3'h1;
      end
   end

   // unlock sequence and exit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unl1_ff <= 1'b0;
         unl2_ff <= 1'b0;
      end else if (byte_done) begin
         if (!unl1_ff) begin
            if (win_open && nxt_byte == CMD_UNLOCK1) begin
               unl1_ff <= 1'b1;
            end
         end else if (!unl2_ff) begin
            if (win_open && nxt_byte == CMD_UNLOCK2) begin
               unl2_ff <= 1'b1;
            end
         end else if (nxt_byte == EXIT_PROGRAMMING_CMD) begin
            unl1_ff <= 1'b0;
            unl2_ff <= 1'b0;
         end
      end
   end

   // scratchpad writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < SCR_WORDS; i++) begin
            scr_ff[i] <= SCR_RESET[NIB*i +: NIB];
         end
      end else if (byte_done && unl2_ff) begin
         case (nxt_byte)
            EXIT_PROGRAMMING_CMD, COMMIT_ALL_CMD, SCRATCH_READ_CMD: begin
            end
            default: begin
               scr_ff[nxt_byte[7:4]] <= nxt_byte[3:0];
            end
         endcase
      end
   end

   // scratchpad read-out sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_mode_ff <= 1'b0;
         rd_idx_ff <= 6'h0;
      end else if (state_ff == ST_RSTL) begin
         rd_mode_ff <= 1'b0;
      end else if (byte_done && unl2_ff && nxt_byte == SCRATCH_READ_CMD) begin
         rd_mode_ff <= 1'b1;
         rd_idx_ff <= 6'h0;
      end else if (smp && rd_mode_ff) begin
         rd_idx_ff <= rd_idx_ff + 6'h1;
         if (rd_idx_ff == RD_LAST) begin
            rd_mode_ff <= 1'b0;
         end
      end
   end

   // commit of whole scratchpad, busy masks the line
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff <= 1'b0;
         bcnt_ff <= 20'h0;
         commit_ff <= 1'b0;
         nv_ff <= SCR_RESET;
      end else begin
         commit_ff <= 1'b0;
         if (byte_done && unl2_ff && nxt_byte == COMMIT_ALL_CMD) begin
            busy_ff <= 1'b1;
            bcnt_ff <= 20'h0;
            commit_ff <= 1'b1;
            nv_ff <= scr_flat;
         end else if (busy_ff) begin
            bcnt_ff <= bcnt_ff + 20'h1;
            if (bcnt_ff == BUSY_L) begin
               busy_ff <= 1'b0;
            end
         end
      end
   end

endmodule
`default_nettype wire

/* File: swp_mst.sv */
`timescale 1ns/1ps
`default_nettype none
module swp_mst import swp_pkg::*; #(
   parameter int RLOW_CYC = RST_LOW_CYC,
   parameter int RREC_CYC = RST_REC_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   swp_if.master bus,
   input wire logic req,
   input wire logic [1:0] op,
   input wire logic [7:0] wdata,
   output logic ready,
   output logic done,
   output logic [7:0] rdata,
   output logic presence
);
   typedef enum logic [2:0] {
      M_IDLE = 3'b000,
      M_LOW = 3'b001,
      M_HIGH = 3'b011,
      M_RLOW = 3'b010,
      M_RHIGH = 3'b110
   } swp_mst_e;

   localparam logic [14:0] W1_L = 15'(W1_LOW_CYC - 1);
   localparam logic [14:0] W0_L = 15'(W0_LOW_CYC - 1);
   localparam logic [14:0] RDL_L = 15'(RD_LOW_CYC - 1);
   localparam logic [14:0] RDS_L = 15'(RD_SMP_CYC - 1);
   localparam logic [14:0] SLOT_L = 15'(SLOT_CYC - 1);
   localparam logic [14:0] RLOW_L = 15'(RLOW_CYC - 1);
   localparam logic [14:0] RREC_L = 15'(RREC_CYC - 1);

   swp_mst_e state_ff;
   logic [2:0] sync_ff;
   logic lvl_ff;
   logic [14:0] cnt_ff;
   logic drv_ff;
   logic [1:0] op_ff;
   logic [7:0] sh_ff;
   logic [2:0] bit_ff;
   logic ready_ff;
   logic done_ff;
   logic [7:0] rdata_ff;
   logic pres_ff;
   logic [14:0] low_len;

   assign bus.mst_out = 1'b0;
   assign bus.mst_oe_n = ~drv_ff;
   assign ready = ready_ff;
   assign done = done_ff;
   assign rdata = rdata_ff;
   assign presence = pres_ff;

   // low time of the current slot
   always_comb begin
      if (op_ff == OP_READ) begin
         low_len = RDL_L;
      end else if (sh_ff[0]) begin
         low_len = W1_L;
      end else begin
         low_len = W0_L;
      end
   end

   // three-stage line synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_ff <= 3'h7;
         lvl_ff <= 1'b1;
      end else begin
         sync_ff <= {sync_ff[1:0], bus.line};
         if (sync_ff[2] == sync_ff[1]) begin
            lvl_ff <= sync_ff[2];
         end
      end
   end

   // reset pulse, write and read slots, eight per byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= M_IDLE;
         cnt_ff <= 15'h0;
         drv_ff <= 1'b0;
         op_ff <= OP_RESET;
         sh_ff <= 8'h0;
         bit_ff <= 3'h0;
         ready_ff <= 1'b1;
         done_ff <= 1'b0;
         rdata_ff <= 8'h0;
         pres_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         case (state_ff)
            M_IDLE: begin
               cnt_ff <= 15'h0;
               bit_ff <= 3'h0;
               if (req && ready_ff) begin
                  ready_ff <= 1'b0;
                  op_ff <= op;
                  sh_ff <= wdata;
                  drv_ff <= 1'b1;
                  state_ff <= (op == OP_RESET) ? M_RLOW : M_LOW;
               end
            end
            M_LOW: begin
               cnt_ff <= cnt_ff + 15'h1;
               if (cnt_ff == low_len) begin
                  drv_ff <= 1'b0;
                  state_ff <= M_HIGH;
               end
            end
            M_HIGH: begin
               cnt_ff <= cnt_ff + 15'h1;
               if (op_ff == OP_READ && cnt_ff == RDS_L) begin
                  sh_ff <= {lvl_ff, sh_ff[7:1]};
               end
               if (cnt_ff == SLOT_L) begin
                  cnt_ff <= 15'h0;
                  bit_ff <= bit_ff + 3'h1;
                  if (op_ff != OP_READ) begin
                     sh_ff <= {1'b0, sh_ff[7:1]};
                  end
                  if (bit_ff == 3'h7) begin
                     state_ff <= M_IDLE;
                     done_ff <= 1'b1;
                     ready_ff <= 1'b1;
                     rdata_ff <= sh_ff;
                  end else begin
                     drv_ff <= 1'b1;
                     state_ff <= M_LOW;
                  end
               end
            end
            M_RLOW: begin
               cnt_ff <= cnt_ff + 15'h1;
               if (cnt_ff == RLOW_L) begin
                  drv_ff <= 1'b0;
                  cnt_ff <= 15'h0;
                  pres_ff <= 1'b0;
                  state_ff <= M_RHIGH;
               end
            end
            M_RHIGH: begin
               cnt_ff <= cnt_ff + 15'h1;
               if (!lvl_ff && cnt_ff > 15'h8) begin
                  pres_ff <= 1'b1;
               end
               if (cnt_ff == RREC_L) begin
                  state_ff <= M_IDLE;
                  done_ff <= 1'b1;
                  ready_ff <= 1'b1;
               end
            end
            default: begin
               state_ff <= M_IDLE;
               drv_ff <= 1'b0;
               ready_ff <= 1'b1;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: swp_props.sv */
`timescale 1ns/1ps
`default_nettype none
module swp_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic dev_out,
   input wire logic dev_oe_n,
   input wire logic mst_out,
   input wire logic mst_oe_n,
   input wire logic line
);
   localparam int ONE_MAX = 600;
   localparam int ZERO_MIN = 2400;
   localparam int PRES_DLY_MIN = 600;
   localparam int PRES_DLY_MAX = 2400;
   localparam int PRES_LEN_MAX = 9600;
   localparam int REC_MIN = 40;
   localparam int RST_SEEN = 4100;
   logic [15:0] mlo_ff;
   logic [15:0] dlo_ff;
   logic [15:0] hi_ff;
   logic [15:0] llo_ff;
   logic line_q_ff;
   logic [15:0] pw_ff;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // length of the current master pull
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) mlo_ff <= 16'h0;
      else if (!mst_oe_n && mlo_ff != 16'hFFFF) mlo_ff <= mlo_ff + 16'h1;
      else if (mst_oe_n) mlo_ff <= 16'h0;
   end
   // length of the current device pull
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) dlo_ff <= 16'h0;
      else if (!dev_oe_n && dlo_ff != 16'hFFFF) dlo_ff <= dlo_ff + 16'h1;
      else if (dev_oe_n) dlo_ff <= 16'h0;
   end
   // time the line has been high; released line counts as long idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) hi_ff <= 16'hFFFF;
      else if (!line) hi_ff <= 16'h0;
      else if (hi_ff != 16'hFFFF) hi_ff <= hi_ff + 16'h1;
   end
   // time the line has been low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) llo_ff <= 16'h0;
      else if (line) llo_ff <= 16'h0;
      else if (llo_ff != 16'hFFFF) llo_ff <= llo_ff + 16'h1;
   end
   // cycles since a reset pulse ended, cleared once the device pulls
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_q_ff <= 1'b1;
         pw_ff <= 16'h0;
      end else begin
         line_q_ff <= line;
         if (line && !line_q_ff && llo_ff > RST_SEEN) begin
            pw_ff <= 16'h1;
         end else if (!dev_oe_n) begin
            pw_ff <= 16'h0;
         end else if (pw_ff != 16'h0 && pw_ff != 16'hFFFF) begin
            pw_ff <= pw_ff + 16'h1;
         end
      end
   end
   a_mst_pulse_len: assert property (
      $rose(mst_oe_n) |-> (mlo_ff <= ONE_MAX) || (mlo_ff >= ZERO_MIN))
      else $error("master pull length between one and zero bands");
   a_pres_delay: assert property (
      $fell(dev_oe_n) |-> !$past(line) || (hi_ff >= PRES_DLY_MIN && hi_ff <= PRES_DLY_MAX))
      else $error("device pulled idle line outside presence delay");
   a_pres_after_rst: assert property (
      pw_ff <= PRES_DLY_MAX)
      else $error("no presence pulse after reset pulse");
   a_dev_pulse_len: assert property (
      $rose(dev_oe_n) |-> dlo_ff != 16'h0 && dlo_ff <= PRES_LEN_MAX)
      else $error("device pull too long");
   a_slot_recovery: assert property (
      $fell(mst_oe_n) |-> hi_ff >= REC_MIN)
      else $error("slot started without recovery time");
   a_dev_open_drain: assert property (
      !dev_oe_n |-> !dev_out)
      else $error("device drives line high");
   a_mst_open_drain: assert property (
      !mst_oe_n |-> !mst_out)
      else $error("master drives line high");
   a_line_idle_high: assert property (
      line == (dev_oe_n && mst_oe_n))
      else $error("line level does not follow pulls");
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import swp_pkg::*;
   localparam int WIN = 70000;
   localparam int BUSY = 100;
   logic clk;
   logic rst_n;
   logic req;
   logic [1:0] op;
   logic [7:0] wdata;
   logic ready;
   logic done;
   logic [7:0] rdata;
   logic presence;
   logic prog_mode;
   logic busy;
   logic commit_pulse;
   logic [63:0] nv_image;
   int num_errors = 0;
   int checked = 0;
   int commits = 0;
   int busy_cyc = 0;
   swp_if bus_if ();
   // device end with reset detect above the write-zero pull length
   swp_dev #(.RESET_CYC(4000), .WIN_CYC(WIN), .BUSY_CYC(BUSY)) u_swp_dev (
      .clk(clk), .rst_n(rst_n), .bus(bus_if.device), .prog_mode(prog_mode),
      .busy(busy), .commit_pulse(commit_pulse), .nv_image(nv_image));
   swp_mst #(.RLOW_CYC(4200), .RREC_CYC(5000)) u_swp_mst (
      .clk(clk), .rst_n(rst_n), .bus(bus_if.master), .req(req), .op(op),
      .wdata(wdata), .ready(ready), .done(done), .rdata(rdata), .presence(presence));
   swp_props u_swp_props (
      .clk(clk), .rst_n(rst_n), .dev_out(bus_if.dev_out), .dev_oe_n(bus_if.dev_oe_n),
      .mst_out(bus_if.mst_out), .mst_oe_n(bus_if.mst_oe_n), .line(bus_if.line));
   // clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // counts commit starts and busy cycles
   always @(posedge clk) begin
      if (commit_pulse === 1'b1) commits++;
      if (busy === 1'b1) busy_cyc++;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      if (num_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // one master operation, waits for done under a bound
   task automatic run_op(input logic [1:0] op_v, input logic [7:0] data);
      int n;
      @(negedge clk);
      req = 1'b1;
      op = op_v;
      wdata = data;
      @(negedge clk);
      req = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 30000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 30000) begin
         num_errors++;
         $display("wrong value at %0t: operation never finished", $time);
         summarize();
      end
   endtask
   // reset pulse answered by presence
   task automatic t_presence;
      check(prog_mode, 64'h0);
      check(nv_image, 64'h0);
      run_op(OP_RESET, 8'h00);
      check(presence, 64'h1);
      check(prog_mode, 64'h0);
   endtask
   // both unlock codes in order inside the window
   task automatic t_unlock;
      run_op(OP_WRITE, CMD_UNLOCK1);
      check(prog_mode, 64'h0);
      run_op(OP_WRITE, CMD_UNLOCK2);
      check(prog_mode, 64'h1);
   endtask
   // scratch write of nibble 1 then commit of the whole scratchpad
   task automatic t_commit;
      run_op(OP_WRITE, 8'h1C);
      check(commits, 64'h0);
      check(busy_cyc, 64'h0);
      check(nv_image, 64'h0);
      run_op(OP_WRITE, COMMIT_ALL_CMD);
      check(commits, 64'h1);
      check(busy_cyc inside {[BUSY - 1:BUSY + 1]}, 64'h1);
      check(nv_image, 64'hC0);
      check(prog_mode, 64'h1);
   endtask
   // exit clears the unlocks and leaves the image alone
   task automatic t_exit;
      run_op(OP_WRITE, EXIT_PROGRAMMING_CMD);
      check(prog_mode, 64'h0);
      check(nv_image, 64'hC0);
      check(commits, 64'h1);
   endtask
   // main sequence
   initial begin
      rst_n = 1'b0;
      req = 1'b0;
      op = OP_RESET;
      wdata = 8'h00;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      t_presence();
      t_unlock();
      t_commit();
      t_exit();
      summarize();
   end
endmodule
`default_nettype wire
